// ===== boot_pin_pkg.sv
// Constants for the reset-phase pin state controller
package boot_pin_pkg;

    // ****************************************
    // Phases and bus personalities
    // ****************************************
    typedef enum logic [1:0] {
        PH_IN_RESET  = 2'b00,
        PH_OUT_RESET = 2'b01,
        PH_PREFETCH  = 2'b10,
        PH_RUN       = 2'b11
    } phase_e;

    localparam logic [1:0] MODE_ISA = 2'h0;
    localparam logic [1:0] MODE_PCMCIA = 2'h1;
    localparam logic [1:0] MODE_LOCAL = 2'h2;

    // ****************************************
    // Pin values
    // ****************************************
    localparam logic [19:0] SA_IN_RESET = 20'hfff00;
    localparam logic [19:0] SA_OUT_RESET = 20'hfff03;
    localparam logic [23:0] BOOT_ADDR = 24'hfffff0;
    localparam logic [15:0] SD_OUT_RESET = 16'h00ff;
    localparam logic [6:0] LA_OUT_RESET = 7'h00;
    localparam logic [23:0] WORD_STEP = 24'h000002;

    // ****************************************
    // Timing defaults in cycles of clk; the prefetch length is in words
    // ****************************************
    localparam int RESET_OUT_CYCLES = 16;
    localparam int PREFETCH_WORDS = 4;
    localparam int WORD_CYCLES = 4;

endpackage

// ===== boot_pin_ctrl.sv
// Reset-phase pin state controller with boot prefetch sequencer
`timescale 1ns/1ns
module boot_pin_ctrl #(
    parameter int OUT_CYCLES = boot_pin_pkg::RESET_OUT_CYCLES,
    parameter int FETCH_WORDS = boot_pin_pkg::PREFETCH_WORDS,
    parameter int FETCH_CYCLES = boot_pin_pkg::WORD_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic external_reset_in_n,
    input wire logic [1:0] strap_mode,
    input wire logic pci_stop_in_n,
    input wire logic pci_devsel_in_n,
    output logic system_reset_out_n,
    output logic [1:0] phase,
    output logic [1:0] bus_mode,
    output logic [2:0] pci_ctl_out_n,
    output logic pci_ctl_oe,
    output logic [19:0] isa_addr,
    output logic [6:0] isa_latch_addr,
    output logic isa_addr_oe,
    output logic [15:0] isa_data,
    output logic isa_data_oe,
    output logic isa_memr_n,
    output logic [4:0] isa_strobe_n,
    output logic [1:0] card_enable_n,
    output logic card_supply_5v_enable,
    output logic card_supply_3v_enable,
    output logic [3:0] flash_select_n,
    output logic [3:0] disk_strobe_n,
    output logic [3:0] disk_select,
    output logic disk_select_oe
);

    // Refuse counts the sequencer cannot serve
    if (OUT_CYCLES < 1 || FETCH_WORDS < 1 || FETCH_CYCLES < 2) begin : g_bad_counts
        $error("boot_pin_ctrl: counts out of range");
    end

    localparam int CW = $clog2(OUT_CYCLES + FETCH_WORDS * FETCH_CYCLES + 1);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0] sync1_ff, sync2_ff;
    logic [4:0] nxt_sync1, nxt_sync2;

    // Pins come from outside, two stages before use
    always_comb begin
        nxt_sync1 = {external_reset_in_n, strap_mode, pci_stop_in_n, pci_devsel_in_n};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Rest levels: reset input held, stop and devsel idle, so no false release
            sync1_ff <= 5'h03;
            sync2_ff <= 5'h03;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    logic rst_in_s, stop_s, devsel_s;
    logic [1:0] strap_s;
    assign rst_in_s = ~sync2_ff[4];
    assign strap_s = sync2_ff[3:2];
    assign stop_s = ~sync2_ff[1];
    assign devsel_s = ~sync2_ff[0];

    // ****************************************
    // Phase sequencer
    // ****************************************
    boot_pin_pkg::phase_e phase_ff, nxt_phase;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [CW-1:0] sub_ff, nxt_sub;
    logic [1:0] mode_ff, nxt_mode;
    logic [23:0] addr_ff, nxt_addr;

    // Phase follows the synced reset input; a new assertion wins from any phase
    always_comb begin
        nxt_phase = phase_ff;
        nxt_cnt = cnt_ff;
        nxt_sub = sub_ff;
        nxt_mode = mode_ff;
        nxt_addr = addr_ff;
        if (rst_in_s) begin
            nxt_phase = boot_pin_pkg::PH_IN_RESET;
            nxt_cnt = '0;
        end else begin
            case (phase_ff)
                boot_pin_pkg::PH_IN_RESET: begin
                    nxt_phase = boot_pin_pkg::PH_OUT_RESET;
                    nxt_mode = (strap_s == 2'h3) ? boot_pin_pkg::MODE_ISA : strap_s;
                    nxt_cnt = '0;
                end
                boot_pin_pkg::PH_OUT_RESET: begin
                    if (cnt_ff == CW'(OUT_CYCLES - 1)) begin
                        nxt_phase = boot_pin_pkg::PH_PREFETCH;
                        nxt_cnt = '0;
                        nxt_sub = '0;
                        nxt_addr = boot_pin_pkg::BOOT_ADDR;
                    end else begin
                        nxt_cnt = cnt_ff + 1'b1;
                    end
                end
                boot_pin_pkg::PH_PREFETCH: begin
                    // Target stop ends fetch early; only watched off the local bus
                    if (mode_ff != boot_pin_pkg::MODE_LOCAL && stop_s && sub_ff != '0) begin
                        nxt_phase = boot_pin_pkg::PH_RUN;
                    end else if (sub_ff == CW'(FETCH_CYCLES - 1)) begin
                        nxt_sub = '0;
                        nxt_addr = addr_ff + boot_pin_pkg::WORD_STEP;
                        if (cnt_ff == CW'(FETCH_WORDS - 1)) begin
                            nxt_phase = boot_pin_pkg::PH_RUN;
                        end else begin
                            nxt_cnt = cnt_ff + 1'b1;
                        end
                    end else begin
                        nxt_sub = sub_ff + 1'b1;
                    end
                end
                boot_pin_pkg::PH_RUN: begin
                    nxt_phase = boot_pin_pkg::PH_RUN;
                end
                default: begin
                    nxt_phase = boot_pin_pkg::PH_IN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= boot_pin_pkg::PH_IN_RESET;
            cnt_ff <= '0;
            sub_ff <= '0;
            mode_ff <= boot_pin_pkg::MODE_ISA;
            addr_ff <= boot_pin_pkg::BOOT_ADDR;
        end else begin
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
            sub_ff <= nxt_sub;
            mode_ff <= nxt_mode;
            addr_ff <= nxt_addr;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    logic in_rst, out_rst, fetch, not_local, isa_like, strobe;
    assign in_rst = (nxt_phase == boot_pin_pkg::PH_IN_RESET);
    assign out_rst = (nxt_phase == boot_pin_pkg::PH_OUT_RESET);
    assign fetch = (nxt_phase == boot_pin_pkg::PH_PREFETCH);
    assign not_local = (nxt_mode != boot_pin_pkg::MODE_LOCAL);
    assign isa_like = not_local;
    assign strobe = fetch && nxt_sub != '0;

    // Pins are registered from next-state so they line up with the phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            system_reset_out_n <= 1'b0;
            phase <= 2'h0;
            bus_mode <= 2'h0;
            pci_ctl_out_n <= 3'h7;
            pci_ctl_oe <= 1'b0;
            isa_addr <= boot_pin_pkg::SA_IN_RESET;
            isa_latch_addr <= boot_pin_pkg::LA_OUT_RESET;
            isa_addr_oe <= 1'b0;
            isa_data <= boot_pin_pkg::SD_OUT_RESET;
            isa_data_oe <= 1'b0;
            isa_memr_n <= 1'b1;
            isa_strobe_n <= 5'h1f;
            card_enable_n <= 2'h3;
            card_supply_5v_enable <= 1'b1;
            card_supply_3v_enable <= 1'b1;
            flash_select_n <= 4'hf;
            disk_strobe_n <= 4'hf;
            disk_select <= 4'h0;
            disk_select_oe <= 1'b0;
        end else begin
            system_reset_out_n <= !(in_rst || out_rst);
            phase <= nxt_phase;
            bus_mode <= nxt_mode;
            // Frame on the first cycle of a word, initiator-ready after; target-ready idle
            pci_ctl_oe <= fetch && not_local;
            pci_ctl_out_n <= {!(fetch && nxt_sub == '0), 1'b1, !strobe};
            isa_addr_oe <= !fetch || isa_like;
            if (in_rst) begin
                isa_addr <= boot_pin_pkg::SA_IN_RESET;
            end else if (out_rst) begin
                isa_addr <= boot_pin_pkg::SA_OUT_RESET;
            end else begin
                isa_addr <= nxt_addr[19:0];
            end
            isa_latch_addr <= (fetch || !(in_rst || out_rst)) ? nxt_addr[23:17]
                : boot_pin_pkg::LA_OUT_RESET;
            isa_data <= boot_pin_pkg::SD_OUT_RESET;
            isa_data_oe <= out_rst;
            isa_memr_n <= !(strobe && isa_like);
            isa_strobe_n <= 5'h1f;
            card_enable_n <= 2'h3;
            card_supply_5v_enable <= 1'b1;
            card_supply_3v_enable <= 1'b1;
            flash_select_n <= 4'hf;
            disk_strobe_n <= 4'hf;
            disk_select <= 4'h0;
            disk_select_oe <= !in_rst;
        end
    end

    // Devsel is sampled for visibility only; fetch timing is fixed
    logic devsel_seen_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            devsel_seen_ff <= 1'b0;
        end else begin
            devsel_seen_ff <= devsel_s && not_local && fetch;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Cycles spent in output reset, kept only for the release-length check
    logic [CW-1:0] hold_len_ff, nxt_hold_len;
    always_comb begin
        nxt_hold_len = (phase == 2'h1) ? hold_len_ff + 1'b1 : '0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_len_ff <= '0;
        end else begin
            hold_len_ff <= nxt_hold_len;
        end
    end

    sequence s_release;
        $rose(system_reset_out_n);
    endsequence

    out_reset_len_a: assert property (s_release |-> hold_len_ff == CW'(OUT_CYCLES))
        else $error("system reset released after wrong hold time");
    sa_in_reset_a: assert property (phase == 2'h0 |-> isa_addr == 20'hfff00)
        else $error("address wrong while reset input held");
    sa_out_reset_a: assert property (phase == 2'h1 |-> isa_addr == 20'hfff03 && isa_addr_oe)
        else $error("address wrong in output reset");
    sd_out_reset_a: assert property (phase == 2'h1 |-> isa_data_oe && isa_data[7:0] == 8'hff)
        else $error("data not 0xff in output reset");
    fetch_start_a: assert property ($rose(phase == 2'h2) |-> {isa_latch_addr, isa_addr[16:0]} == 24'hfffff0)
        else $error("fetch did not start at boot address");
    pci_local_a: assert property (bus_mode == 2'h2 || phase != 2'h2 |-> !pci_ctl_oe)
        else $error("pci lines driven outside allowed case");
    strobe_high_a: assert property (phase != 2'h0 |-> isa_strobe_n == 5'h1f && disk_strobe_n == 4'hf)
        else $error("strobe went active");
    card_off_a: assert property (card_enable_n == 2'h3 && card_supply_5v_enable && card_supply_3v_enable)
        else $error("card enable went active");
    flash_off_a: assert property (flash_select_n == 4'hf)
        else $error("flash select went active");
    disk_sel_a: assert property (phase != 2'h0 |-> disk_select_oe && disk_select == 4'h0)
        else $error("disk select not low");
    mode_stable_a: assert property (phase != 2'h0 && $past(phase) != 2'h0 |-> $stable(bus_mode))
        else $error("bus personality changed after reset");

endmodule // boot_pin_ctrl

// ===== boot_target_model.sv
// Boot memory target model answering the device's first prefetch cycles
`timescale 1ns/1ns
module boot_target_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] ctl_n,
    input wire logic ctl_oe,
    input wire logic stop_req,
    output logic stop_n,
    output logic devsel_n
);
    logic claimed_ff;

    // ****************************************
    // Claim and stop
    // ****************************************
    // Claim one cycle after frame; released lines sit at the pull-up level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            claimed_ff <= 1'b0;
        end else begin
            claimed_ff <= ctl_oe && !ctl_n[2];
        end
    end

    // Stop only while a transfer is driven and the bench asks for it
    assign devsel_n = !(ctl_oe && (claimed_ff || !ctl_n[0]));
    assign stop_n = !(ctl_oe && stop_req);
endmodule // boot_target_model

// ===== bus_pin_reset_state_control_tb.sv
// Self-checking bench of the reset-phase pin state controller
`timescale 1ns/1ns
module bus_pin_reset_state_control_tb;
    typedef struct {logic [1:0] strap; logic [1:0] mode; logic drive; logic stop;} row_s;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ext_n = 1'b0;
    logic [1:0] strap_mode = 2'h0;
    logic stop_req = 1'b0;
    logic stop_n, devsel_n, sro_n, ctl_oe, addr_oe, data_oe, memr_n, v5, v3, dsel_oe;
    logic [1:0] phase, bus_mode, card_n;
    logic [2:0] ctl_n;
    logic [19:0] addr;
    logic [6:0] latch_addr;
    logic [15:0] data;
    logic [4:0] strobe_n;
    logic [3:0] flash_n, dstrobe_n, dsel;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    row_s rows[5] = '{'{2'h0, 2'h0, 1'b1, 1'b0}, '{2'h1, 2'h1, 1'b1, 1'b0},
        '{2'h2, 2'h2, 1'b0, 1'b0}, '{2'h3, 2'h0, 1'b1, 1'b0}, '{2'h2, 2'h2, 1'b0, 1'b1}};

    always #5 clk = ~clk;

    boot_pin_ctrl #(.OUT_CYCLES(2), .FETCH_WORDS(3), .FETCH_CYCLES(2)) u_dut (
        .clk(clk), .resetn(resetn), .external_reset_in_n(ext_n), .strap_mode(strap_mode),
        .pci_stop_in_n(stop_n), .pci_devsel_in_n(devsel_n), .system_reset_out_n(sro_n),
        .phase(phase), .bus_mode(bus_mode), .pci_ctl_out_n(ctl_n), .pci_ctl_oe(ctl_oe),
        .isa_addr(addr), .isa_latch_addr(latch_addr), .isa_addr_oe(addr_oe),
        .isa_data(data), .isa_data_oe(data_oe), .isa_memr_n(memr_n),
        .isa_strobe_n(strobe_n), .card_enable_n(card_n), .card_supply_5v_enable(v5),
        .card_supply_3v_enable(v3), .flash_select_n(flash_n), .disk_strobe_n(dstrobe_n),
        .disk_select(dsel), .disk_select_oe(dsel_oe));

    boot_target_model u_target (.clk(clk), .resetn(resetn), .ctl_n(ctl_n),
        .ctl_oe(ctl_oe), .stop_req(stop_req), .stop_n(stop_n), .devsel_n(devsel_n));

    // ****************************************
    // Compare, wait and verdict
    // ****************************************
    task automatic check_val(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_phase(input logic [1:0] p);
        int k;
        for (k = 0; k < 100 && phase !== p; k++) tick(1);
        if (phase !== p) begin
            fail_count++;
            $display("wrong value phase expected %h seen %h", p, phase);
            report_and_stop();
        end
    endtask

    // Pins that hold their level in every phase
    task automatic check_static();
        check_val("strobes", 24'h1f, {19'h0, strobe_n});
        check_val("cards", 24'hf, {20'h0, card_n, v5, v3});
        check_val("flash", 24'hf, {20'h0, flash_n});
        check_val("disk_strobes", 24'hf, {20'h0, dstrobe_n});
    endtask

    // One full reset sequence for a strap row
    task automatic run_row(input row_s r);
        ext_n = 1'b0;
        stop_req = r.stop;
        wait_phase(2'h0);
        tick(3);
        check_val("sro_in", 24'h0, {23'h0, sro_n});
        check_val("ctl_oe_in", 24'h0, {23'h0, ctl_oe});
        check_static();
        strap_mode = r.strap;
        ext_n = 1'b1;
        wait_phase(2'h1);
        strap_mode = ~r.strap;
        check_val("mode", {22'h0, r.mode}, {22'h0, bus_mode});
        check_val("addr_out", 24'hfff03, {4'h0, addr});
        check_val("data_out", 24'hff, {8'h0, data});
        check_val("data_oe", 24'h1, {23'h0, data_oe});
        check_val("dsel", 24'h10, {19'h0, dsel_oe, dsel});
        check_val("ctl_oe_out", 24'h0, {23'h0, ctl_oe});
        check_val("sro_out", 24'h0, {23'h0, sro_n});
        check_static();
        wait_phase(2'h2);
        check_val("mode_kept", {22'h0, r.mode}, {22'h0, bus_mode});
        check_val("sro_run", 24'h1, {23'h0, sro_n});
        check_val("boot_addr", 24'hfffff0, {latch_addr[6:3], addr});
        check_val("ctl_oe_fetch", {23'h0, r.drive}, {23'h0, ctl_oe});
        check_val("addr_oe", {23'h0, r.drive}, {23'h0, addr_oe});
        check_val("frame", 24'h0, {23'h0, ctl_n[2]});
        // Three words of two cycles unless the target stops the burst in the second word
        for (n = 0; n < 20 && phase === 2'h2; n++) begin
            if (n == 1) begin
                check_val("memr", {23'h0, !r.drive}, {23'h0, memr_n});
                check_val("trdy_irdy", 24'h2, {22'h0, ctl_n[1:0]});
            end
            tick(1);
        end
        check_val("fetch_len", (r.stop && r.drive) ? 24'h4 : 24'h6, n[23:0]);
        check_val("phase_run", 24'h3, {22'h0, phase});
        check_val("data_oe_run", 24'h0, {23'h0, data_oe});
        check_static();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        tick(6);
        resetn = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // Stop in ISA mode must cut the burst short
        run_row('{2'h0, 2'h0, 1'b1, 1'b1});
        // Input reasserted mid-prefetch drops back to input reset
        ext_n = 1'b0;
        wait_phase(2'h0);
        strap_mode = 2'h1;
        ext_n = 1'b1;
        wait_phase(2'h2);
        ext_n = 1'b0;
        tick(4);
        check_val("abort_phase", 24'h0, {22'h0, phase});
        check_val("abort_sro", 24'h0, {23'h0, sro_n});
        check_val("abort_ctl_oe", 24'h0, {23'h0, ctl_oe});
        // Chip reset mid-run
        ext_n = 1'b1;
        wait_phase(2'h3);
        resetn = 1'b0;
        #2;
        check_val("chip_reset", 24'h0, {22'h0, phase});
        check_static();
        report_and_stop();
    end
endmodule // bus_pin_reset_state_control_tb
